// ===== design/dse_consts.svh
`ifndef DSE_CONSTS_SVH
`define DSE_CONSTS_SVH

// Control register map
`define DSE_ECHO_ADDR      8'h59
`define DSE_ECHO_MASK      16'h000F
`define DSE_ECHO_RESET     16'h0000
// Bus address of this block, value is arbitrary
`define DSE_I2C_DEV_ADDR   7'h2A

// Serial timing
`define DSE_CLK_HZ         20000000
`define DSE_BAUD_MIN_BPS   1200
`define DSE_BAUD_MAX_BPS   115200
`define DSE_DIV_MAX        16'(`DSE_CLK_HZ / `DSE_BAUD_MIN_BPS)
`define DSE_DIV_MIN        16'((`DSE_CLK_HZ + `DSE_BAUD_MAX_BPS - 1) / `DSE_BAUD_MAX_BPS)
`define DSE_FRAME_BITS     4'h9
`define DSE_RX_FRAME_BITS  4'hA

// Transmit buffer
`define DSE_FIFO_DEPTH     32
`define DSE_DATA_W         8

`endif

// ===== design/dse_pkg.sv
package dse_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_RX_BYTE,
    I2C_ACK,
    I2C_TX_BYTE,
    I2C_RX_ACK
  } dse_i2c_state_type;
endpackage

// ===== design/dse_fifo.sv
module dse_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic [W-1:0]  out_data_r;
  logic          out_valid_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign push      = in_valid && in_ready;
  assign pop       = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_data  = out_data_r;
  assign out_valid = out_valid_r;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_data_r  <= '0;
      out_valid_r <= 1'b0;
    end else if (pop) begin
      out_data_r  <= mem_r[rd_ptr_r];
      out_valid_r <= 1'b1;
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule

// ===== design/dse_top.sv
// Functional notes
// R1: 16-bit echo register at 89 over I2C
// R2: Bits 0-3 enable echo for slots 1-4
// R3: Echo enables reset to zero
// R4: Half-duplex driver direction follows outgoing data
// R5: Bit rates 1200 to 115200 programmable
// R6: Full duplex, transmit paused without clear-to-send
// R7: Half-duplex port red receive, green transmit
// R8: Point-to-point port red receive, green transmit
// R9: Each port has its own channel
// R10: Other register bits read zero, ignore writes
`include "dse_consts.svh"

module dse_top (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  input  wire logic [1:0]       slot_id,
  input  wire logic [1:0][7:0]  host_tx_data,
  input  wire logic [1:0]       host_tx_valid,
  output logic [1:0]            host_tx_ready,
  output logic [1:0][7:0]       host_rx_data,
  output logic [1:0]            host_rx_valid,
  input  wire logic [1:0]       host_rx_ready,
  input  wire logic [1:0][15:0] baud_div,
  input  wire logic             rs485_rxd,
  output logic                  rs485_txd,
  output logic                  rs485_de,
  input  wire logic             rs232_rxd,
  output logic                  rs232_txd,
  input  wire logic             rs232_cts_n,
  output logic                  rs232_rts_n,
  output logic [1:0]            led_rx_red,
  output logic [1:0]            led_tx_green
);
  function automatic logic [15:0] clamp_div(input logic [15:0] d);
    if (d < `DSE_DIV_MIN) begin
      return `DSE_DIV_MIN;
    end
    if (d > `DSE_DIV_MAX) begin
      return `DSE_DIV_MAX;
    end
    return d;
  endfunction

  // Pin synchronisers: {slot_id, sda, scl, cts_n, rxd232, rxd485}
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  logic       scl_d_r;
  logic       sda_d_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 7'h1F;
      pin_s2_r <= 7'h1F;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      pin_s1_r <= {slot_id, sda_i, scl_i, rs232_cts_n, rs232_rxd, rs485_rxd};
      pin_s2_r <= pin_s1_r;
      scl_d_r  <= pin_s2_r[3];
      sda_d_r  <= pin_s2_r[4];
    end
  end

  logic scl_s;
  logic sda_s;
  logic cts_n_s;
  assign scl_s   = pin_s2_r[3];
  assign sda_s   = pin_s2_r[4];
  assign cts_n_s = pin_s2_r[2];

  // Slot position caught once the synchroniser holds the strap
  logic [1:0] slot_r;
  logic [1:0] slot_fill_r;
  logic       slot_done_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_r      <= 2'h0;
      slot_fill_r <= 2'h0;
      slot_done_r <= 1'b0;
    end else begin
      slot_fill_r <= {slot_fill_r[0], 1'b1};
      if (slot_fill_r[1] && !slot_done_r) begin
        slot_r      <= pin_s2_r[6:5];
        slot_done_r <= 1'b1;
      end
    end
  end

  // I2C slave
  dse_pkg::dse_i2c_state_type st_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       i2c_start;
  logic       i2c_stop;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic       rw_r;
  logic [7:0] ptr_r;
  logic [7:0] hi_r;
  logic       nack_r;
  logic       sda_low_r;
  logic       wr_stb;
  logic [15:0] echo_r;
  logic [15:0] rd_word;

  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;
  assign i2c_start = scl_s && scl_d_r && !sda_s && sda_d_r;
  assign i2c_stop  = scl_s && scl_d_r && sda_s && !sda_d_r;
  assign wr_stb    = scl_fall && (st_r == dse_pkg::I2C_RX_BYTE) && (bit_r == 4'h8)
                     && (byte_r == 2'h3) && !rw_r;
  assign rd_word   = (ptr_r == `DSE_ECHO_ADDR) ? echo_r : 16'h0000; // [R10]
  assign sda_o     = 1'b0;
  assign sda_oe    = sda_low_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r      <= dse_pkg::I2C_IDLE;
      sh_r      <= 8'h00;
      bit_r     <= 4'h0;
      byte_r    <= 2'h0;
      rw_r      <= 1'b0;
      ptr_r     <= 8'h00;
      hi_r      <= 8'h00;
      nack_r    <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (i2c_start) begin
      st_r      <= dse_pkg::I2C_RX_BYTE;
      bit_r     <= 4'h0;
      byte_r    <= 2'h0;
      rw_r      <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (i2c_stop) begin
      st_r      <= dse_pkg::I2C_IDLE;
      sda_low_r <= 1'b0;
    end else begin
      case (st_r)
        dse_pkg::I2C_RX_BYTE: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            bit_r     <= 4'h0;
            st_r      <= dse_pkg::I2C_ACK;
            sda_low_r <= 1'b1;
            case (byte_r)
              2'h0: begin
                rw_r <= sh_r[0];
                if (sh_r[7:1] != `DSE_I2C_DEV_ADDR) begin
                  st_r      <= dse_pkg::I2C_IDLE;
                  sda_low_r <= 1'b0;
                end
              end
              2'h1: ptr_r <= sh_r;
              2'h2: hi_r <= sh_r;
              default: ;
            endcase
            byte_r <= (byte_r == 2'h3) ? 2'h3 : byte_r + 2'h1;
          end
        end
        dse_pkg::I2C_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              st_r      <= dse_pkg::I2C_TX_BYTE;
              sh_r      <= rd_word[15:8];
              hi_r      <= rd_word[7:0];
              sda_low_r <= !rd_word[15];
            end else begin
              st_r      <= dse_pkg::I2C_RX_BYTE;
              sda_low_r <= 1'b0;
            end
          end
        end
        dse_pkg::I2C_TX_BYTE: begin
          if (scl_fall) begin
            if (bit_r == 4'h7) begin
              st_r      <= dse_pkg::I2C_RX_ACK;
              bit_r     <= 4'h0;
              sda_low_r <= 1'b0;
            end else begin
              sh_r      <= {sh_r[6:0], 1'b0};
              bit_r     <= bit_r + 4'h1;
              sda_low_r <= !sh_r[6];
            end
          end
        end
        dse_pkg::I2C_RX_ACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_r <= dse_pkg::I2C_IDLE;
            end else begin
              st_r      <= dse_pkg::I2C_TX_BYTE;
              sh_r      <= hi_r;
              hi_r      <= 8'h00;
              sda_low_r <= !hi_r[7];
            end
          end
        end
        default: st_r <= dse_pkg::I2C_IDLE;
      endcase
    end
  end

  // Echo control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      echo_r <= `DSE_ECHO_RESET; // [R3]
    end else if (wr_stb && ptr_r == `DSE_ECHO_ADDR) begin // [R1]
      echo_r <= {hi_r, sh_r} & `DSE_ECHO_MASK; // [R10]
    end
  end

  logic slot_echo;
  assign slot_echo = echo_r[slot_r]; // [R2]

  // Serial channels: 0 half-duplex, 1 point-to-point
  logic [1:0] txd;
  logic [1:0] tx_busy;
  logic [1:0] rx_busy;
  logic [1:0] rx_src;
  logic [1:0] fifo_v;
  logic [1:0] tx_go;
  logic [1:0][7:0] fifo_d;

  assign rx_src[0] = tx_busy[0] ? (slot_echo ? txd[0] : 1'b1) : pin_s2_r[0]; // [R2]
  assign rx_src[1] = pin_s2_r[1]; // [R6]

  for (genvar c = 0; c < 2; c++) begin : g_ch // [R9]
    logic [15:0] div_eff;
    logic [15:0] tdiv_r;
    logic [3:0]  tbits_r;
    logic [8:0]  tsh_r;
    logic        txd_r;
    logic        tbusy_r;
    logic [15:0] rdiv_r;
    logic [3:0]  rbits_r;
    logic [7:0]  rsh_r;
    logic        rbusy_r;
    logic [7:0]  rdata_r;
    logic        rvalid_r;

    assign div_eff    = clamp_div(baud_div[c]); // [R5]
    assign tx_go[c]   = !tbusy_r && fifo_v[c] && ((c == 0) || !cts_n_s); // [R6]
    assign txd[c]     = txd_r;
    assign tx_busy[c] = tbusy_r;
    assign rx_busy[c] = rbusy_r;
    assign host_rx_data[c]  = rdata_r;
    assign host_rx_valid[c] = rvalid_r;

    dse_fifo #(.W(`DSE_DATA_W), .D(`DSE_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_data   (host_tx_data[c]),
      .in_valid  (host_tx_valid[c]),
      .in_ready  (host_tx_ready[c]),
      .out_data  (fifo_d[c]),
      .out_valid (fifo_v[c]),
      .out_ready (tx_go[c])
    );

    // Transmitter: start, 8 data LSB first, stop
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        tdiv_r  <= 16'h0000;
        tbits_r <= 4'h0;
        tsh_r   <= 9'h1FF;
        txd_r   <= 1'b1;
        tbusy_r <= 1'b0;
      end else if (tx_go[c]) begin
        txd_r   <= 1'b0;
        tsh_r   <= {1'b1, fifo_d[c]};
        tbits_r <= `DSE_FRAME_BITS;
        tdiv_r  <= div_eff - 16'h0001;
        tbusy_r <= 1'b1;
      end else if (tbusy_r) begin
        if (tdiv_r != 16'h0000) begin
          tdiv_r <= tdiv_r - 16'h0001;
        end else if (tbits_r == 4'h0) begin
          tbusy_r <= 1'b0;
        end else begin
          txd_r   <= tsh_r[0];
          tsh_r   <= {1'b1, tsh_r[8:1]};
          tbits_r <= tbits_r - 4'h1;
          tdiv_r  <= div_eff - 16'h0001;
        end
      end
    end

    // Receiver: samples at bit centres, drops bad frames
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rdiv_r   <= 16'h0000;
        rbits_r  <= 4'h0;
        rsh_r    <= 8'h00;
        rbusy_r  <= 1'b0;
        rdata_r  <= 8'h00;
        rvalid_r <= 1'b0;
      end else begin
        rvalid_r <= 1'b0;
        if (!rbusy_r) begin
          if (!rx_src[c]) begin
            rbusy_r <= 1'b1;
            rbits_r <= `DSE_RX_FRAME_BITS;
            rdiv_r  <= {1'b0, div_eff[15:1]};
          end
        end else if (rdiv_r != 16'h0000) begin
          rdiv_r <= rdiv_r - 16'h0001;
        end else begin
          rdiv_r  <= div_eff - 16'h0001;
          rbits_r <= rbits_r - 4'h1;
          if (rbits_r == `DSE_RX_FRAME_BITS) begin
            rbusy_r <= !rx_src[c];
          end else if (rbits_r == 4'h1) begin
            rbusy_r  <= 1'b0;
            rdata_r  <= rx_src[c] ? rsh_r : rdata_r;
            rvalid_r <= rx_src[c];
          end else begin
            rsh_r <= {rx_src[c], rsh_r[7:1]};
          end
        end
      end
    end
  end

  // Pins and indicators
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs232_rts_n <= 1'b1;
    end else begin
      rs232_rts_n <= !host_rx_ready[1]; // [R6]
    end
  end

  assign rs485_txd    = txd[0];
  assign rs485_de     = tx_busy[0]; // [R4]
  assign rs232_txd    = txd[1];
  assign led_rx_red   = rx_busy & ~tx_busy & 2'h1 | rx_busy & 2'h2; // [R7] [R8]
  assign led_tx_green = tx_busy; // [R7] [R8]

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  echo_reset_a: assert property (@(posedge clk) disable iff (1'b0) !rstn |=> echo_r == 16'h0000) // [R3]
    else $error("echo register not cleared by reset");
  reserved_zero_a: assert property (echo_r[15:4] == 12'h000) // [R10]
    else $error("reserved bits set");
  echo_write_a: assert property (wr_stb && ptr_r == `DSE_ECHO_ADDR |=> // [R1]
    echo_r == ({$past(hi_r), $past(sh_r)} & 16'h000F))
    else $error("echo write not stored");
  other_addr_a: assert property (wr_stb && ptr_r != `DSE_ECHO_ADDR |=> $stable(echo_r)) // [R1]
    else $error("write to other address changed register");
  dir_start_a: assert property (tx_go[0] |=> rs485_de && !rs485_txd) // [R4]
    else $error("driver not enabled on start bit");
  cts_hold_a: assert property (cts_n_s && !tx_busy[1] |=> !tx_busy[1]) // [R6]
    else $error("transmit started without clear-to-send");
  echo_path_a: assert property (rs485_de |-> rx_src[0] == (slot_echo ? rs485_txd : 1'b1)) // [R2]
    else $error("echo path wrong");
  div_range_a: assert property (g_ch[0].div_eff >= 16'h00AE && g_ch[1].div_eff >= 16'h00AE // [R5]
    && g_ch[0].div_eff <= 16'h411A && g_ch[1].div_eff <= 16'h411A)
    else $error("bit period out of range");
  led485_a: assert property (!rs485_de |-> !led_tx_green[0] ##0 led_rx_red[0] == rx_busy[0]) // [R7]
    else $error("half-duplex indicator wrong");
  led232_a: assert property ($rose(tx_busy[1]) |-> led_tx_green[1] && !rs232_txd) // [R8]
    else $error("point-to-point indicator wrong");

  tx485_c: cover property (tx_go[0] ##1 rs485_de);
  rx232_c: cover property (host_rx_valid[1]);
  echo_c: cover property (rs485_de && slot_echo && rx_busy[0]);
endmodule

// ===== tb/dse_far_peer.sv
module dse_far_peer (
  input  wire logic        clk,
  input  wire logic [15:0] div,
  input  wire logic        line_in,
  input  wire logic        pause,
  output logic             line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  initial line_out = 1'b1;
  // Centre-sampled receiver, LSB first, keeps frames with a good stop bit
  always begin
    @(negedge line_in);
    repeat (div / 2) @(posedge clk);
    if (line_in === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        b[i] = line_in;
      end
      repeat (div) @(posedge clk);
      if (line_in === 1'b1) rx_q.push_back(b);
    end
  end
  // One frame, sent only while the device is ready to take data
  task automatic send(input logic [7:0] d);
    while (pause !== 1'b0) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (div) @(posedge clk);
    end
  endtask
endmodule

// ===== tb/test_dual_serial_echo_control.sv
`include "dse_consts.svh"

module test_dual_serial_echo_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 8;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             scl = 1'b1;
  logic             sda_m = 1'b1;
  logic             sda_oe, sda_o, sda, bus, p0_in, p0_out;
  logic [1:0]       slot_id = 2'h1;
  logic [1:0][7:0]  tx_d = '0;
  logic [1:0]       tx_v = 2'h0;
  logic [1:0]       tx_rdy, rx_v, red, green;
  logic [1:0][7:0]  rx_d;
  logic [1:0]       rx_rdy = 2'h3;
  logic [1:0][15:0] div = {16'h00AE, 16'h00AE};
  logic             txd0, de, r232_in, txd1, rts_n;
  logic             cts_n = 1'b1;
  logic [15:0]      w, v;
  logic [7:0]       b, b2;
  logic [8:0]       r;
  integer           seed = 50;
  int               bad_count = 0;
  int               checks_done = 0;
  int               cyc = 0;
  int               n;
  logic [7:0]       q0[$], q1[$], exp1[$];

  // Open-drain data line and the shared differential pair
  assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
  assign bus = de ? txd0 : p0_out;
  assign p0_in = de ? txd0 : 1'b1;

  dse_top u_dse_top (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .slot_id(slot_id), .host_tx_data(tx_d), .host_tx_valid(tx_v),
    .host_tx_ready(tx_rdy), .host_rx_data(rx_d), .host_rx_valid(rx_v),
    .host_rx_ready(rx_rdy), .baud_div(div), .rs485_rxd(bus), .rs485_txd(txd0),
    .rs485_de(de), .rs232_rxd(r232_in), .rs232_txd(txd1), .rs232_cts_n(cts_n),
    .rs232_rts_n(rts_n), .led_rx_red(red), .led_tx_green(green));
  dse_far_peer p0 (.clk(clk), .div(div[0]), .line_in(p0_in), .pause(1'b0),
    .line_out(p0_out));
  dse_far_peer p1 (.clk(clk), .div(div[1]), .line_in(txd1), .pause(rts_n),
    .line_out(r232_in));

  always #25 clk = ~clk;

  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (rx_v[0] === 1'b1) q0.push_back(rx_d[0]);
    if (rx_v[1] === 1'b1) q1.push_back(rx_d[1]);
    if (cyc == 98000) begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [15:0] exp_reg(input logic [15:0] d);
    return d & 16'h000F;
  endfunction

  function automatic logic [15:0] exp_echo(input logic [15:0] d, input logic [1:0] s);
    return {15'h0000, d[s]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wq();
    repeat (Q) @(negedge clk);
  endtask

  task automatic io(input logic [8:0] d);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      wq();
      scl = 1'b1;
      wq();
      r[i] = sda;
      scl = 1'b0;
      wq();
    end
  endtask

  task automatic start();
    sda_m = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_m = 1'b0;
    wq();
    scl = 1'b0;
    wq();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_m = 1'b1;
    wq();
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    start();
    io({`DSE_I2C_DEV_ADDR, 2'b01});
    chk(r[0], 1'b0);
    io({p, 1'b1});
    io({d[15:8], 1'b1});
    io({d[7:0], 1'b1});
    stop();
  endtask

  task automatic rd(input logic [7:0] p);
    start();
    io({`DSE_I2C_DEV_ADDR, 2'b01});
    io({p, 1'b1});
    start();
    io({`DSE_I2C_DEV_ADDR, 2'b11});
    io(9'h1FE);
    v[15:8] = r[8:1];
    io(9'h1FF);
    v[7:0] = r[8:1];
    stop();
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    rd(`DSE_ECHO_ADDR);
    chk(v, 16'h0000);
    rd(8'h5A);
    chk(v, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($random(seed));
      wr(`DSE_ECHO_ADDR, w);
      rd(`DSE_ECHO_ADDR);
      chk(v, exp_reg(w));
    end
    wr(8'h5A, 16'hFFFF);
    rd(`DSE_ECHO_ADDR);
    chk(v, exp_reg(w));
    start();
    io({`DSE_I2C_DEV_ADDR ^ 7'h01, 2'b01});
    chk(r[0], 1'b1);
    stop();
    for (int k = 0; k < 2; k++) begin
      rx_rdy[1] = k[0];
      repeat (4) @(negedge clk);
      chk(rts_n, !k[0]);
    end
    for (int e = 0; e < 2; e++) begin
      if (e == 1) begin
        slot_id = 2'h2;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        rd(`DSE_ECHO_ADDR);
        chk(v, 16'h0000);
      end
      w = 16'($random(seed));
      w[slot_id] = e[0];
      wr(`DSE_ECHO_ADDR, w);
      div[0] = e ? 16'h015C : 16'h00AE;
      b = 8'($random(seed));
      q0 = {};
      while (tx_rdy[0] !== 1'b1) @(negedge clk);
      tx_d[0] = b;
      tx_v[0] = 1'b1;
      @(negedge clk);
      tx_v[0] = 1'b0;
      for (n = 0; n < 20 && de !== 1'b1; n++) @(negedge clk);
      chk(green[0], 1'b1);
      chk(txd0, 1'b0);
      for (n = 0; n < 9000 && de === 1'b1; n++) @(negedge clk);
      chk(n >= 10 * div[0] - 2 && n <= 10 * div[0] + 3, 1'b1);
      repeat (4) @(negedge clk);
      chk(p0.rx_q.pop_front(), b);
      chk(16'(q0.size()), exp_echo(w, slot_id));
    end
    b = 8'($random(seed));
    q0 = {};
    fork
      p0.send(b);
      begin
        repeat (1740) @(negedge clk);
        chk(red[0], 1'b1);
      end
    join
    repeat (4) @(negedge clk);
    chk(q0.pop_front(), b);
    chk(16'(q1.size()), 16'h0000);
    n = 0;
    tx_v[1] = 1'b1;
    while (tx_rdy[1] === 1'b1 && n < 40) begin
      tx_d[1] = 8'($random(seed));
      exp1.push_back(tx_d[1]);
      @(negedge clk);
      n++;
    end
    tx_v[1] = 1'b0;
    chk(n >= 32 && n <= 34, 1'b1);
    chk({txd1, green[1]}, 2'b10);
    cts_n = 1'b0;
    b2 = 8'($random(seed));
    fork
      p1.send(b2);
      begin
        repeat (900) @(negedge clk);
        chk({red[1], green[1]}, 2'b11);
      end
    join
    for (int m = 0; m < 70000 && p1.rx_q.size() < n; m++) @(negedge clk);
    for (int i = 0; i < n; i++) chk(p1.rx_q[i], exp1[i]);
    chk(q1[0], b2);
    close_out();
  end
endmodule
